// >>> pmx_params.svh
// Constants for the PHY pin/strap block and its MAC partner.
// Assumes includers use these as plain text macros.
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH

// Management register indices and bit positions
`define PMX_R_CTRL      5'h00
`define PMX_R_ICS       5'h1B
`define PMX_R_PHYC      5'h1F
`define PMX_DUPLEX_BIT  8
`define PMX_ISO_BIT     10
`define PMX_IPOL_BIT    9

// Timing counts in ref_clk cycles; PMX_MDIO_PRE in management clock bits
`define PMX_STRAP_CYC   16
`define PMX_MDIO_PRE    32
`define PMX_LINK_HALF   8
`define PMX_MDC_HALF    8

// Strap pin pulls: bit0 rxd0 .. bit3 rxd3, 4 rxdv, 5 rxer, 6 col, 7 crs
`define PMX_PIN_PULL    8'h09
`define PMX_RMII_OE_N   8'hCC

// Controller register byte offsets
`define PMX_A_CMD       4'h0
`define PMX_A_STAT      4'h4
`define PMX_A_MASK      4'h8

`endif

// >>> pmx_pkg.sv
// Types shared by the PHY end and the MAC end.
// Assumes pmx_params.svh holds all numeric constants.
package pmx_pkg;

  typedef enum logic [1:0] {M_PRE, M_HDR, M_RD, M_WR} pmx_mst_t;
  typedef enum logic {X_IDLE, X_RUN} pmx_xst_t;

  typedef struct packed {
    logic [15:0] sy1;
    logic [15:0] sy2;
    logic        ref_q;
    logic        mdc_q;
    logic        txen_q;
    logic        rxv_q;
    logic        col_q;
    logic [4:0]  scnt;
    logic        sdone;
    logic [2:0]  maddr;
    logic [2:0]  cfg;
    logic [15:0] reg0;
    logic [15:0] reg1f;
    logic [7:0]  ien;
    logic [7:0]  ist;
    logic [7:0]  div;
    logic        lclk;
    logic        txc;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe_n;
    logic        rh;
    logic        th;
    logic        rx_take;
    logic        tx_vld;
    logic [3:0]  tx_nib;
    pmx_mst_t    mst;
    logic [5:0]  bcnt;
    logic [15:0] sh;
    logic [4:0]  ra;
    logic        mdo;
    logic        mdo_oe_n;
    logic        irq;
    logic        xfb;
  } pmx_phy_st_t;

  typedef struct packed {
    logic [11:0] sy1;
    logic [11:0] sy2;
    logic        txc_q;
    logic        rxc_q;
    logic        irq_q;
    logic        rxv_q;
    logic [7:0]  div;
    logic        lclk;
    logic [7:0]  mdiv;
    logic        mdc;
    pmx_xst_t    xst;
    logic [6:0]  bc;
    logic [31:0] fr;
    logic        rd;
    logic [15:0] rdat;
    logic        mdo;
    logic        mdo_oe_n;
    logic        txen;
    logic [3:0]  txd;
    logic        th;
    logic        rh;
    logic        tx_ready;
    logic        rx_valid;
    logic        rx_err;
    logic [3:0]  rx_data;
    logic [2:0]  st;
    logic [2:0]  mask;
    logic        irq;
    logic [31:0] rdata;
  } pmx_mac_st_t;

endpackage

// >>> pmx_if.sv
// Pins between the PHY end and the MAC end.
// Assumes the bench drives ext_en/ext_val to override strap pulls.
`timescale 1ns/1ps
`include "pmx_params.svh"
interface pmx_if;
  logic       ref_clock_in;
  logic       crystal_feedback;
  logic       mdc;
  logic       mdio_mac_o;
  logic       mdio_mac_oe_n;
  logic       mdio_phy_o;
  logic       mdio_phy_oe_n;
  logic       mdio;
  logic       txc;
  logic       rxc;
  logic       txen;
  logic [3:0] txd;
  logic       irq_out;
  logic [7:0] pin_o;
  logic [7:0] pin_oe_n;
  logic [7:0] pin_level;
  logic [7:0] ext_en;
  logic [7:0] ext_val;

  // Open-drain data line with pull-up
  assign mdio = (mdio_mac_oe_n | mdio_mac_o) & (mdio_phy_oe_n | mdio_phy_o);
  // Dual-purpose pins: driven value, else external strap, else pull
  assign pin_level = (~pin_oe_n & pin_o)
                   | (pin_oe_n & ((ext_en & ext_val) | (~ext_en & `PMX_PIN_PULL)));

  modport phy (
    input  ref_clock_in, mdc, mdio, txen, txd, pin_level,
    output crystal_feedback, mdio_phy_o, mdio_phy_oe_n, txc, rxc,
    output irq_out, pin_o, pin_oe_n
  );
  modport mac (
    input  mdio, txc, rxc, irq_out, pin_level, crystal_feedback,
    output ref_clock_in, mdc, mdio_mac_o, mdio_mac_oe_n, txen, txd
  );
endinterface

// >>> pmx_phy.sv
// PHY end: MAC-side pins, strap capture, management slave, interrupt.
// Assumes the MAC end supplies ref_clock_in and management clock.
// Contract
// - System supplies reference clock per mode
// - Crystal feedback only in MII crystal use
// - Management data synchronous to master clock
// - Strap rxd3..1 as address bits 0..2
// - Strap rxd0 as duplex, control bit 8
// - Strap col, crs, rxdv as config 0..2
// - Strap receive error pin as isolate
// - Interrupt sources enabled and read via 1Bh
// - Interrupt polarity from 1Fh bit 9
// - PHY drives txc; MAC drives txen, txd
// - MII: PHY drives rxc, rxd, rxdv, rxer
// - MII: PHY drives collision and carrier sense
// - RMII: MAC drives only txd1..0 and txen; the code also drives txd3..2 low
// - RMII: PHY drives rxd1..0, crs_dv, rxer
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pmx_params.svh"
module pmx_phy
  import pmx_pkg::*;
#(
  parameter bit RMII      = 1'b0,
  parameter bit XTAL_USED = 1'b1,
  parameter int LINK_HALF = `PMX_LINK_HALF
)
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  pmx_if.phy              lnk,
  input  wire logic [3:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       rx_error,
  input  wire logic       col_in,
  input  wire logic       crs_in,
  output logic            rx_take,
  output logic [3:0]      tx_data,
  output logic            tx_valid,
  output logic [2:0]      management_address,
  output logic [2:0]      cfg_strap,
  output logic            strap_done,
  output logic            duplex,
  output logic            isolate
);

  localparam logic [7:0] DIV_LAST  = 8'(LINK_HALF - 1);
  localparam logic [4:0] SCNT_LAST = 5'(`PMX_STRAP_CYC - 1);
  localparam logic [5:0] PRE_N     = 6'(`PMX_MDIO_PRE);

  pmx_phy_st_t r;
  pmx_phy_st_t n;
  logic [7:0]  pins;
  logic [3:0]  txd_s;
  logic        txen_s;
  logic        mdio_s;
  logic        mdc_s;
  logic        ref_s;
  logic        wrap;
  logic        launch;
  logic        samp;
  logic        dren;
  logic        mrise;
  logic        lvl;
  logic [12:0] hdr;
  logic [15:0] wd;
  logic [7:0]  clr;
  logic [2:0]  ev;

  // Second stage of the pin synchronisers
  assign {pins, txd_s, txen_s, mdio_s, mdc_s, ref_s} = r.sy2;

  // Next-state logic
  always_comb
  begin
    n = r;
    clr = 8'h00;
    ev = 3'b000;
    n.sy1 = {lnk.pin_level, lnk.txd, lnk.txen, lnk.mdio, lnk.mdc, lnk.ref_clock_in};
    n.sy2 = r.sy1;
    n.ref_q = ref_s;
    n.mdc_q = mdc_s;
    hdr = {r.sh[11:0], mdio_s};
    wd = {r.sh[14:0], mdio_s};
    mrise = mdc_s & ~r.mdc_q;

    // Link timing: own divider in MII, reference edges in RMII
    wrap = (r.div == DIV_LAST);
    n.div = wrap ? 8'h00 : r.div + 8'h01;
    n.lclk = r.lclk ^ wrap;
    n.txc = RMII ? 1'b0 : n.lclk;
    launch = RMII ? (ref_s & ~r.ref_q) : (wrap & ~r.lclk);
    samp = RMII ? (~ref_s & r.ref_q) : (wrap & r.lclk);

    // Strap capture a fixed time after reset release
    if (!r.sdone)
    begin
      n.scnt = r.scnt + 5'h01;
      if (r.scnt == SCNT_LAST)
      begin
        n.sdone = 1'b1;
        n.maddr = {pins[1], pins[2], pins[3]};
        n.reg0[`PMX_DUPLEX_BIT] = pins[0];
        n.cfg = {pins[4], pins[7], pins[6]};
        n.reg0[`PMX_ISO_BIT] = pins[5];
      end
    end

    // Pin drivers stay off until straps are held and while isolated
    dren = r.sdone & ~r.reg0[`PMX_ISO_BIT];
    if (!dren)
      n.pin_oe_n = 8'hFF;
    else
      n.pin_oe_n = RMII ? `PMX_RMII_OE_N : 8'h00;

    // Receive path toward the MAC
    n.rx_take = 1'b0;
    if (dren && launch)
    begin
      n.pin_o[5] = rx_error;
      if (RMII)
      begin
        n.pin_o[1:0] = r.rh ? rx_data[3:2] : rx_data[1:0];
        n.pin_o[4] = rx_valid | crs_in;
        n.rh = rx_valid & ~r.rh;
        n.rx_take = rx_valid & r.rh;
      end
      else
      begin
        n.pin_o[4:0] = {rx_valid, rx_data};
        n.pin_o[7:6] = {crs_in, col_in};
        n.rx_take = rx_valid;
      end
    end

    // Transmit path from the MAC
    n.tx_vld = 1'b0;
    if (dren && samp)
    begin
      n.txen_q = txen_s;
      ev[1] = txen_s & ~r.txen_q;
      n.th = txen_s & RMII & ~r.th;
      if (txen_s && RMII)
      begin
        if (!r.th)
          n.tx_nib[1:0] = txd_s[1:0];
        else
        begin
          n.tx_nib[3:2] = txd_s[1:0];
          n.tx_vld = 1'b1;
        end
      end
      else if (txen_s)
      begin
        n.tx_nib = txd_s;
        n.tx_vld = 1'b1;
      end
    end

    // Management slave, bits taken on rising management clock
    if (mrise)
    begin
      case (r.mst)
        M_PRE:
        begin
          if (mdio_s)
            n.bcnt = (r.bcnt == PRE_N) ? r.bcnt : r.bcnt + 6'h01;
          else
          begin
            if (r.bcnt == PRE_N)
              n.mst = M_HDR;
            n.bcnt = 6'h00;
          end
        end
        M_HDR:
        begin
          n.sh = wd;
          n.bcnt = r.bcnt + 6'h01;
          if (r.bcnt == 6'h0C)
          begin
            n.bcnt = 6'h00;
            n.ra = hdr[4:0];
            n.mst = M_PRE;
            if (hdr[12] && hdr[9:5] == {2'b00, r.maddr})
            begin
              if (hdr[11:10] == 2'b10)
              begin
                n.mst = M_RD;
                case (hdr[4:0])
                  `PMX_R_CTRL: n.sh = r.reg0;
                  `PMX_R_ICS:  n.sh = {r.ien, r.ist};
                  `PMX_R_PHYC: n.sh = r.reg1f;
                  default:     n.sh = 16'h0000;
                endcase
              end
              else if (hdr[11:10] == 2'b01)
                n.mst = M_WR;
            end
          end
        end
        M_RD:
        begin
          n.bcnt = r.bcnt + 6'h01;
          if (r.bcnt == 6'h00)
          begin
            n.mdo = 1'b0;
            n.mdo_oe_n = 1'b0;
          end
          else if (r.bcnt == 6'h11)
          begin
            n.mdo_oe_n = 1'b1;
            n.mst = M_PRE;
            n.bcnt = 6'h00;
          end
          else
          begin
            n.mdo = r.sh[15];
            n.sh = {r.sh[14:0], 1'b0};
          end
        end
        M_WR:
        begin
          n.sh = wd;
          n.bcnt = r.bcnt + 6'h01;
          if (r.bcnt == 6'h11)
          begin
            n.mst = M_PRE;
            n.bcnt = 6'h00;
            case (r.ra)
              `PMX_R_CTRL: n.reg0 = wd;
              `PMX_R_ICS:
              begin
                n.ien = wd[15:8];
                clr = wd[7:0];
              end
              `PMX_R_PHYC: n.reg1f = wd;
              default: ;
            endcase
          end
        end
        default: n.mst = M_PRE;
      endcase
    end

    // Sticky events: set wins over a write-one clear
    ev[0] = rx_valid & ~r.rxv_q;
    ev[2] = col_in & ~r.col_q;
    n.rxv_q = rx_valid;
    n.col_q = col_in;
    n.ist = (r.ist & ~clr) | {5'h00, ev};
    lvl = |(r.ist & r.ien);
    n.irq = r.reg1f[`PMX_IPOL_BIT] ? lvl : ~lvl;
    n.xfb = (!RMII && XTAL_USED) ? ~ref_s : 1'b0;
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.pin_oe_n <= 8'hFF;
      r.mdo_oe_n <= 1'b1;
      r.irq <= 1'b1;
    end
    else
      r <= n;
  end

  // Outputs straight from state
  assign lnk.crystal_feedback = r.xfb;
  assign lnk.mdio_phy_o = r.mdo;
  assign lnk.mdio_phy_oe_n = r.mdo_oe_n;
  assign lnk.txc = r.txc;
  assign lnk.rxc = r.txc;
  assign lnk.irq_out = r.irq;
  assign lnk.pin_o = r.pin_o;
  assign lnk.pin_oe_n = r.pin_oe_n;
  assign rx_take = r.rx_take;
  assign tx_data = r.tx_nib;
  assign tx_valid = r.tx_vld;
  assign management_address = r.maddr;
  assign cfg_strap = r.cfg;
  assign strap_done = r.sdone;
  assign duplex = r.reg0[`PMX_DUPLEX_BIT];
  assign isolate = r.reg0[`PMX_ISO_BIT];

endmodule

// >>> pmx_mac.sv
// MAC end: reference clock, management master, data streams, registers.
// Assumes a simple register port driven on the ref_clk domain.
`timescale 1ns/1ps
`include "pmx_params.svh"
module pmx_mac
  import pmx_pkg::*;
#(
  parameter bit RMII      = 1'b0,
  parameter bit IRQ_HIGH  = 1'b0,
  parameter int LINK_HALF = `PMX_LINK_HALF,
  parameter int MDC_HALF  = `PMX_MDC_HALF
)
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  pmx_if.mac               lnk,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic [3:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [3:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_err,
  output logic             irq
);

  localparam logic [7:0] REF_LAST = 8'(RMII ? LINK_HALF - 1 : 2 * LINK_HALF - 1);
  localparam logic [7:0] MDC_LAST = 8'(MDC_HALF - 1);

  pmx_mac_st_t r;
  pmx_mac_st_t n;
  logic [7:0]  pins;
  logic        mdio_s;
  logic        irq_s;
  logic        txc_s;
  logic        rxc_s;
  logic        wrap;
  logic        mwrap;
  logic        launch;
  logic        samp;
  logic        act;
  logic [2:0]  clr;
  logic [2:0]  ev;

  // Second stage of the pin synchronisers
  assign {pins, mdio_s, irq_s, txc_s, rxc_s} = r.sy2;

  // Next-state logic
  always_comb
  begin
    n = r;
    clr = 3'b000;
    ev = 3'b000;
    n.sy1 = {lnk.pin_level, lnk.mdio, lnk.irq_out, lnk.txc, lnk.rxc};
    n.sy2 = r.sy1;
    n.txc_q = txc_s;
    n.rxc_q = rxc_s;

    // Reference clock out, half rate in MII
    wrap = (r.div == REF_LAST);
    n.div = wrap ? 8'h00 : r.div + 8'h01;
    n.lclk = r.lclk ^ wrap;
    launch = RMII ? (wrap & ~r.lclk) : (txc_s & ~r.txc_q);
    samp = RMII ? (wrap & r.lclk) : (~rxc_s & r.rxc_q);

    // Transmit toward the PHY
    n.tx_ready = 1'b0;
    if (launch)
    begin
      if (tx_valid && RMII)
      begin
        n.txen = 1'b1;
        n.txd = {2'b00, r.th ? tx_data[3:2] : tx_data[1:0]};
        n.th = ~r.th;
        n.tx_ready = r.th;
      end
      else if (tx_valid)
      begin
        n.txen = 1'b1;
        n.txd = tx_data;
        n.tx_ready = 1'b1;
      end
      else
      begin
        n.txen = 1'b0;
        n.txd = 4'h0;
        n.th = 1'b0;
      end
    end

    // Receive from the PHY
    n.rx_valid = 1'b0;
    if (samp)
    begin
      n.rxv_q = pins[4];
      ev[1] = pins[4] & ~r.rxv_q;
      n.rh = pins[4] & RMII & ~r.rh;
      if (pins[4] && RMII && !r.rh)
        n.rx_data[1:0] = pins[1:0];
      else if (pins[4])
      begin
        if (RMII)
          n.rx_data[3:2] = pins[1:0];
        else
          n.rx_data = pins[3:0];
        n.rx_err = pins[5];
        n.rx_valid = 1'b1;
      end
    end

    // Management master: drive after falling, sample on rising clock
    mwrap = (r.mdiv == MDC_LAST);
    n.mdiv = mwrap ? 8'h00 : r.mdiv + 8'h01;
    case (r.xst)
      X_IDLE: n.mdc = 1'b0;
      X_RUN:
      begin
        if (mwrap && !r.mdc)
        begin
          n.mdc = 1'b1;
          if (r.rd && r.bc > 7'd48)
            n.rdat = {r.rdat[14:0], mdio_s};
        end
        else if (mwrap && r.bc == 7'h40)
        begin
          // Frame ends only after a full high phase on the last bit
          n.mdc = 1'b0;
          n.xst = X_IDLE;
          n.mdo_oe_n = 1'b1;
          ev[0] = 1'b1;
        end
        else if (mwrap)
        begin
          n.mdc = 1'b0;
          n.mdo_oe_n = r.rd && r.bc >= 7'd46;
          n.mdo = (r.bc < 7'd32) ? 1'b1 : r.fr[31];
          if (r.bc >= 7'd32)
            n.fr = {r.fr[30:0], 1'b0};
          n.bc = r.bc + 7'h01;
        end
      end
      default: n.xst = X_IDLE;
    endcase

    // Register writes; a command while busy is dropped
    if (reg_wr)
    begin
      case (reg_addr)
        `PMX_A_CMD:
        begin
          if (r.xst == X_IDLE)
          begin
            n.fr = {2'b01, reg_wdata[26] ? 2'b10 : 2'b01, reg_wdata[25:16], 2'b10, reg_wdata[15:0]};
            n.rd = reg_wdata[26];
            n.xst = X_RUN;
            n.bc = 7'h00;
            n.mdiv = 8'h00;
          end
        end
        `PMX_A_STAT: clr = reg_wdata[2:0];
        `PMX_A_MASK: n.mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    // Read data stands one cycle after the strobe only
    n.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `PMX_A_CMD:  n.rdata = {r.xst == X_RUN, 15'h0000, r.rdat};
        `PMX_A_STAT: n.rdata = {29'h0000_0000, r.st};
        `PMX_A_MASK: n.rdata = {29'h0000_0000, r.mask};
        default:     n.rdata = 32'h0000_0000;
      endcase
    end

    // Sticky status, set wins over clear
    act = IRQ_HIGH ? irq_s : ~irq_s;
    ev[2] = act & ~r.irq_q;
    n.irq_q = act;
    n.st = (r.st & ~clr) | ev;
    n.irq = |(r.st & r.mask);
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.mdo_oe_n <= 1'b1;
      r.irq_q <= 1'b1; // No false event while the syncs fill
    end
    else
      r <= n;
  end

  // Outputs straight from state
  assign lnk.ref_clock_in = r.lclk;
  assign lnk.mdc = r.mdc;
  assign lnk.mdio_mac_o = r.mdo;
  assign lnk.mdio_mac_oe_n = r.mdo_oe_n;
  assign lnk.txen = r.txen;
  assign lnk.txd = r.txd;
  assign reg_rdata = r.rdata;
  assign tx_ready = r.tx_ready;
  assign rx_data = r.rx_data;
  assign rx_valid = r.rx_valid;
  assign rx_err = r.rx_err;
  assign irq = r.irq;

endmodule

// >>> pmx_props.sv
// Checker on the pin bundle between the PHY end and the MAC end.
// Assumes MII mode with the default link and management divider counts.
`timescale 1ns/1ps
module pmx_props
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       ref_clock_in,
  input wire logic       crystal_feedback,
  input wire logic       mdc,
  input wire logic       mdio_mac_oe_n,
  input wire logic       mdio_phy_oe_n,
  input wire logic       txc,
  input wire logic       rxc,
  input wire logic       txen,
  input wire logic [3:0] txd,
  input wire logic       irq_out,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n
);
  logic [5:0] since_rst_r;

  // Cycles since reset release, saturating
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      since_rst_r <= 6'h00;
    else if (since_rst_r != 6'h3F)
      since_rst_r <= since_rst_r + 6'h01;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Pin relations
  ref_period_a: assert property ($rose(ref_clock_in) |-> ##15 ref_clock_in ##1 !ref_clock_in)
    else $error("reference clock half period wrong");
  xfb_invert_a: assert property ($changed(ref_clock_in) |-> ##[2:6] (crystal_feedback == !ref_clock_in))
    else $error("crystal feedback does not follow reference");
  mdio_owner_a: assert property (!mdio_phy_oe_n |-> mdio_mac_oe_n)
    else $error("both ends drive management data");
  mdc_high_a: assert property ($rose(mdc) |-> mdc [*8] ##1 !mdc)
    else $error("management clock high phase wrong");
  mdc_low_a: assert property ($fell(mdc) |-> !mdc [*8])
    else $error("management clock low phase too short");
  strap_hold_a: assert property (since_rst_r < 6'h11 |-> pin_oe_n == 8'hFF)
    else $error("strap pin driven before capture");
  irq_idle_a: assert property (since_rst_r < 6'h0E |-> irq_out)
    else $error("interrupt active right after reset");
  rxc_half_a: assert property ($rose(rxc) |-> rxc [*8] ##1 !rxc)
    else $error("receive clock high phase wrong");
  tx_launch_a: assert property (($changed(txd) || $changed(txen)) |-> txc)
    else $error("transmit pins moved in low clock phase");
  rx_launch_a: assert property (($changed(pin_o) && !pin_oe_n[0]) |-> txc)
    else $error("receive pins moved in low clock phase");

  // Main scenarios reached
  cover property ($fell(mdio_phy_oe_n));
  cover property ($rose(txen));
  cover property ($fell(irq_out));
  cover property ($fell(pin_oe_n[0]));
endmodule

// >>> tb.sv
// Bench joining the PHY end and the MAC end through the pin bundle.
// Assumes MII mode, default divider counts and a 100 MHz ref_clk.
`timescale 1ns/1ps
`include "pmx_params.svh"
module tb
  import pmx_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  rx_data, tx_data, phy_txd, mac_rxd, reg_addr;
  logic        rx_valid, rx_error, col_in, crs_in, tx_valid, reg_wr, reg_rd;
  logic        rx_take, phy_txv, mac_txr, mac_rxv, mac_rxe, irq, done, duplex, isolate;
  logic [2:0]  maddr, cfg;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [15:0] d16;
  logic [7:0]  lvl;
  logic [3:0]  rx_exp[8], tx_exp[8], rxq[$], txq[$];
  int          errors, samples_checked, seed, n;

  pmx_if lnk();

  pmx_phy pmx_phy_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_error(rx_error), .col_in(col_in), .crs_in(crs_in), .rx_take(rx_take),
    .tx_data(phy_txd), .tx_valid(phy_txv), .management_address(maddr), .cfg_strap(cfg),
    .strap_done(done), .duplex(duplex), .isolate(isolate));
  pmx_mac pmx_mac_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(mac_txr), .rx_data(mac_rxd), .rx_valid(mac_rxv), .rx_err(mac_rxe),
    .irq(irq));
  pmx_props pmx_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ref_clock_in(lnk.ref_clock_in),
    .crystal_feedback(lnk.crystal_feedback), .mdc(lnk.mdc), .mdio_mac_oe_n(lnk.mdio_mac_oe_n),
    .mdio_phy_oe_n(lnk.mdio_phy_oe_n), .txc(lnk.txc), .rxc(lnk.rxc), .txen(lnk.txen), .txd(lnk.txd),
    .irq_out(lnk.irq_out), .pin_o(lnk.pin_o), .pin_oe_n(lnk.pin_oe_n));

  // Clock
  always #5 ref_clk = ~ref_clk;

  // Collect nibbles delivered at both user sides
  always @(posedge ref_clk)
  begin
    if (mac_rxv === 1'b1)
      rxq.push_back(mac_rxd);
    if (phy_txv === 1'b1)
      txq.push_back(phy_txd);
  end

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait for take (0), ready (1) or strap done (2), bounded
  task automatic wait_hi(input int sel, input int lim);
    logic [2:0] s;
    int         k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
      s = {done, mac_txr, rx_take};
      if (k > lim)
      begin
        errors++;
        give_verdict();
      end
    end
    while (s[sel] !== 1'b1);
    n = k;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // One management frame, polled until the controller is idle
  task automatic mgmt(input logic op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    int k;
    k = 0;
    wr(`PMX_A_CMD, {5'h00, op, pa, ra, d});
    do
    begin
      rdr(`PMX_A_CMD);
      k++;
      if (k > 2000)
      begin
        errors++;
        give_verdict();
      end
    end
    while (rd[31] !== 1'b0);
  endtask

  // Reset with given strap levels, then check what was latched
  task automatic do_reset(input logic [7:0] en, input logic [7:0] val);
    sys_rst <= 1'b1;
    lnk.ext_en <= en;
    lnk.ext_val <= val;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wait_hi(2, 40);
    lvl = (en & val) | (~en & `PMX_PIN_PULL);
    chk(n, `PMX_STRAP_CYC + 1);
    chk(maddr, {lvl[1], lvl[2], lvl[3]});
    chk(duplex, lvl[0]);
    chk(cfg, {lvl[4], lvl[7], lvl[6]});
    chk(isolate, lvl[5]);
  endtask

  task automatic send_rx();
    foreach (rx_exp[i])
    begin
      rx_data <= rx_exp[i];
      rx_valid <= 1'b1;
      wait_hi(0, 200);
    end
    rx_valid <= 1'b0;
  endtask

  task automatic send_tx();
    foreach (tx_exp[i])
    begin
      tx_data <= tx_exp[i];
      tx_valid <= 1'b1;
      wait_hi(1, 200);
    end
    tx_valid <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    seed = 32'h8768;
    errors = 0;
    samples_checked = 0;
    n = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {rx_data, rx_valid, rx_error, col_in, crs_in, tx_data, tx_valid} = '0;
    do_reset(8'h00, 8'h00);
    repeat (2)
      do_reset(8'($random(seed)), 8'($random(seed)));
    do_reset(8'hFF, 8'h0B);
    rdr(`PMX_A_STAT);
    chk(rd, 32'h0000_0000);
    mgmt(1'b1, 5'h05, `PMX_R_CTRL, 16'h0000);
    chk(rd[`PMX_DUPLEX_BIT], 1'b1);
    d16 = 16'($random(seed)) & 16'hFBFF;
    mgmt(1'b0, 5'h05, `PMX_R_CTRL, d16);
    mgmt(1'b1, 5'h05, `PMX_R_CTRL, 16'h0000);
    chk(rd[15:0], d16);
    chk(duplex, d16[`PMX_DUPLEX_BIT]);
    mgmt(1'b1, 5'h06, `PMX_R_CTRL, 16'h0000);
    chk(rd[15:0], 16'hFFFF);
    wr(`PMX_A_MASK, 32'h4);
    wr(`PMX_A_STAT, 32'h7);
    mgmt(1'b0, 5'h05, `PMX_R_ICS, 16'h0100);
    chk(lnk.irq_out, 1'b1);
    foreach (rx_exp[i])
    begin
      rx_exp[i] = (i == 0) ? 4'hF : 4'($random(seed));
      tx_exp[i] = (i == 0) ? 4'h0 : 4'($random(seed));
    end
    rxq.delete();
    txq.delete();
    fork
      send_rx();
      send_tx();
    join
    repeat (100) @(posedge ref_clk);
    chk(rxq.size(), 8);
    chk(txq.size(), 8);
    foreach (rx_exp[i])
    begin
      chk(rxq[i], rx_exp[i]);
      chk(txq[i], tx_exp[i]);
    end
    chk(lnk.irq_out, 1'b0);
    chk(irq, 1'b1);
    rdr(`PMX_A_STAT);
    chk(rd[2:0], 3'h7);
    wr(`PMX_A_MASK, 32'h0);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    wr(`PMX_A_MASK, 32'h4);
    wr(`PMX_A_STAT, 32'h7);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    mgmt(1'b1, 5'h05, `PMX_R_ICS, 16'h0000);
    chk(rd[0], 1'b1);
    mgmt(1'b0, 5'h05, `PMX_R_ICS, 16'h0101);
    chk(lnk.irq_out, 1'b1);
    for (int v = 1; v >= 0; v--)
    begin
      col_in <= v[0];
      crs_in <= v[0];
      rx_error <= v[0];
      repeat (80) @(posedge ref_clk);
      chk(lnk.pin_level[7:5], {3{v[0]}});
    end
    mgmt(1'b0, 5'h05, `PMX_R_PHYC, 16'h0200);
    chk(lnk.irq_out, 1'b0);
    mgmt(1'b0, 5'h05, `PMX_R_ICS, 16'h0400);
    chk(lnk.irq_out, 1'b1);
    give_verdict();
  end
endmodule
